// ### hdl/mem_ctrl_pkg.sv
// Shared constants and types of the bank select and refresh controller
package mem_ctrl_pkg;
    localparam int          NUM_BANKS        = 8;
    localparam int          BURST_BEATS      = 4;
    // Register byte offsets
    localparam logic [7:0]  OFS_GLOBAL       = 8'h00;
    localparam logic [7:0]  OFS_FAULT        = 8'h04;
    localparam logic [7:0]  OFS_ARB_ID       = 8'h08;
    localparam logic [7:0]  OFS_BANK_FIRST   = 8'h40;
    localparam logic [7:0]  OFS_BANK_LAST    = 8'h7C;
    // Global configuration fields
    localparam int          GL_REFRESH_INTERVAL_COUNT_LSB     = 0;
    localparam int          GL_REFRESH_INTERVAL_COUNT_W       = 8;
    localparam int          GL_REFRESH_ON_BIT_BIT      = 8;
    localparam int          GL_PBF_BIT       = 9;
    localparam int          GL_PGWAIT_BIT    = 10;
    localparam logic [31:0] GLOBAL_RESET     = 32'h0000_0000;
    // Fault flag fields
    localparam int          FLT_WP_BIT       = 0;
    localparam int          FLT_PAR_BIT      = 1;
    // Arbitration id fields and reset values
    localparam int          ARB_BCLR_LSB     = 0;
    localparam int          ARB_SERIAL_DMA_CHANNEL_LSB     = 4;
    localparam int          ARB_IDMA_LSB     = 8;
    localparam logic [2:0]  BCLR_ID_RESET    = 3'h3;
    localparam logic [2:0]  SERIAL_DMA_CHANNEL_ID_RESET    = 3'h4;
    localparam logic [2:0]  IDMA_ID_RESET    = 3'h2;
    // Function code of processor space cycles
    localparam logic [3:0]  FC_CPU_SPACE     = 4'h7;
    // Refresh timing
    localparam int          CLK_PERIOD_NS    = 40;
    localparam int          REFRESH_NS       = 15600;
    localparam int          REFRESH_REF_CNT  = 24;
    localparam int          REFRESH_CYCLES   = REFRESH_NS / CLK_PERIOD_NS;
    localparam int          PRESCALE_CYCLES  = REFRESH_CYCLES / (REFRESH_REF_CNT + 2);

    typedef struct packed {
        logic [3:0]  top_bits;
        logic [16:0] base_addr;
        logic [2:0]  rsvd;
        logic [3:0]  func_code;
        logic        host_burst_ack_on;
        logic        parity_check_on;
        logic        write_guard;
        logic        valid;
    } bank_base_cfg_type;

    typedef struct packed {
        logic [3:0]  access_wait_count;
        logic [16:0] block_size_mask;
        logic [2:0]  rsvd;
        logic [3:0]  function_code_mask;
        logic        rsvd0;
        logic [1:0]  burst_beat_wait;
        logic        dram_bank_select;
    } bank_size_timing_cfg_type;

    typedef struct packed {
        logic [31:0] addr;
        logic [3:0]  fc;
        logic        write;
        logic        burst;
    } access_req_type;

    typedef bank_base_cfg_type        [NUM_BANKS-1:0] bank_base_arr_type;
    typedef bank_size_timing_cfg_type [NUM_BANKS-1:0] bank_size_arr_type;
endpackage : mem_ctrl_pkg

// ### hdl/bank_decode.sv
// Address and function code decode of the eight banks
`timescale 1ns/10ps
`default_nettype none
module bank_decode (
    input  wire mem_ctrl_pkg::bank_base_arr_type base_cfg,
    input  wire mem_ctrl_pkg::bank_size_arr_type size_cfg,
    input  wire mem_ctrl_pkg::access_req_type    req,
    input  wire logic                            we_lines_mode,
    output logic                                 hit,
    output logic [2:0]                           hit_idx
);
    import mem_ctrl_pkg::*;

    function automatic logic bank_match(input bank_base_cfg_type b,
                                        input bank_size_timing_cfg_type s,
                                        input access_req_type r,
                                        input logic we_mode);
        logic addr_ok;
        logic top_ok;
        logic fc_ok;
        addr_ok = ((r.addr[27:11] ^ b.base_addr) & s.block_size_mask) == 17'h0_0000; // R3
        top_ok  = we_mode ? (b.top_bits == 4'h0) : (r.addr[31:28] == b.top_bits); // R14
        if (s.function_code_mask == 4'h0) begin
            fc_ok = (r.fc != FC_CPU_SPACE); // R5
        end else begin
            fc_ok = ((r.fc ^ b.func_code) & s.function_code_mask) == 4'h0;
        end
        bank_match = b.valid && addr_ok && top_ok && fc_ok; // R12
    endfunction : bank_match

    always_comb begin
        hit     = 1'b0;
        hit_idx = 3'h0;
        for (int i = NUM_BANKS - 1; i >= 0; i--) begin
            if (bank_match(base_cfg[i], size_cfg[i], req, we_lines_mode)) begin
                hit     = 1'b1; // R20
                hit_idx = 3'(i);
            end
        end
    end
endmodule : bank_decode
`default_nettype wire

// ### hdl/bank_select_refresh_ctrl.sv
// Bank select, wait state, burst and refresh controller with Wishbone registers
// Overview of operation
// R1: Refresh interval count spaces refreshes; count 24 gives 15.6 us at 25 MHz.
// R2: Eight banks, each with base and size/timing registers and own select line.
// R3: Block size mask sets the bytes a bank covers from its base.
// R4: Access wait count sets wait states inserted for each bank access.
// R5: Zero function code mask selects on all codes except processor space.
// R6: Burst beat wait 00 gives one-clock beats, 01 gives two-clock beats.
// R7: Host burst acknowledge bit lets the bank run external processor bursts.
// R8: Fault flags record write-protect and parity faults; no setup needed.
// R9: Write guard bit write-protects a bank; meant for EPROM and flash.
// R10: Parity check bit enables parity checking for that bank only.
// R11: Parity bus fault bit makes parity errors end with bus error, except in companion mode.
// R12: A bank's select line responds only when its valid bit is set.
// R13: DRAM select bit gives the bank row strobe and refresh handling.
// R14: Base bits place the window; top bits zero with byte write lines.
// R15: Software keeps bank windows and the register block from overlapping.
// R16: Serial DMA and refresh above the bus clear id preempt independent DMA; here serial DMA must also exceed the IDMA id, refresh always preempts.
// R17: Page wait control must not apply in processor companion mode.
// R18: Refresh on bit must be set for periodic refresh cycles.
// R19: Software waits about 100 us and eight reads before using DRAM.
// R20: At most one select per access; match needs address, valid, code.
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module bank_select_refresh_ctrl (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [7:0]                   wb_adr_i,
    input  wire logic [3:0]                   wb_sel_i,
    input  wire logic [31:0]                  wb_dat_i,
    output logic      [31:0]                  wb_dat_o,
    output logic                              wb_ack_o,
    input  wire logic                         acc_req,
    input  wire mem_ctrl_pkg::access_req_type acc,
    input  wire logic                         parity_err_in,
    input  wire logic                         companion_mode,
    input  wire logic                         we_lines_mode,
    input  wire logic                         serial_dma_channel_req,
    input  wire logic                         idma_busy,
    output logic      [7:0]                   bank_sel_n,
    output logic                              acc_ack,
    output logic                              acc_berr,
    output logic                              acc_miss,
    output logic                              refresh_busy,
    output logic                              idma_clear
);
    import mem_ctrl_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_WAIT, S_BEAT, S_END, S_REFRESH} state_type;

    state_type         state_ff;
    logic [31:0]       global_mem_cfg_ff;
    bank_base_arr_type bank_base_cfg_ff;
    bank_size_arr_type bank_size_timing_cfg_ff;
    logic [1:0]        mem_fault_flags_ff;
    logic [2:0]        bclr_id_ff;
    logic [2:0]        serial_dma_channel_id_ff;
    logic [2:0]        idma_id_ff;
    logic [7:0]        prescale_ff;
    logic [7:0]        interval_ff;
    logic              refresh_tick;
    logic              refresh_pend_ff;
    logic [2:0]        bank_idx_ff;
    logic [4:0]        wait_cnt_ff;
    logic [1:0]        beat_cnt_ff;
    logic              hit;
    logic [2:0]        hit_idx;
    logic              wb_req;
    logic              wb_wr;
    logic [31:0]       nxt_dat;
    logic [1:0]        fault_set;
    logic [1:0]        fault_clr;
    logic [7:0]        dram_valid;
    logic [7:0]        bank_valid;
    logic              beat_done;
    logic              start;
    logic              wp_fault;
    logic              par_fault;
    logic              pbf_on;
    logic              pg_wait;

    bank_decode u_decode (
        .base_cfg      (bank_base_cfg_ff),
        .size_cfg      (bank_size_timing_cfg_ff),
        .req           (acc),
        .we_lines_mode (we_lines_mode),
        .hit           (hit),
        .hit_idx       (hit_idx)
    );

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] sel);
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                old[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        merge = old;
    endfunction : merge

    function automatic logic is_bank(input logic [7:0] adr, input logic size_reg);
        is_bank = (adr >= OFS_BANK_FIRST) && (adr <= OFS_BANK_LAST) && (adr[2] == size_reg);
    endfunction : is_bank

    assign wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr     = wb_req && wb_we_i;
    assign pbf_on    = global_mem_cfg_ff[GL_PBF_BIT] && !companion_mode; // R11
    assign pg_wait   = global_mem_cfg_ff[GL_PGWAIT_BIT] && !companion_mode; // R17
    assign start     = (state_ff == S_IDLE) && acc_req && !refresh_pend_ff;
    assign wp_fault  = start && hit && acc.write && bank_base_cfg_ff[hit_idx].write_guard; // R9
    assign par_fault = (state_ff == S_WAIT || state_ff == S_BEAT) && beat_done && !acc.write
                       && bank_base_cfg_ff[bank_idx_ff].parity_check_on && parity_err_in; // R10
    assign beat_done = (wait_cnt_ff == 5'h00);

    always_comb begin
        for (int i = 0; i < NUM_BANKS; i++) begin
            bank_valid[i] = bank_base_cfg_ff[i].valid;
            dram_valid[i] = bank_base_cfg_ff[i].valid
                            && bank_size_timing_cfg_ff[i].dram_bank_select; // R13
        end
    end

    // Wishbone slave, registered ack one cycle after the request
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    always_comb begin
        nxt_dat = 32'h0000_0000;
        if (wb_adr_i == OFS_GLOBAL) begin
            nxt_dat = global_mem_cfg_ff;
        end else if (wb_adr_i == OFS_FAULT) begin
            nxt_dat = {30'h0000_0000, mem_fault_flags_ff}; // R8
        end else if (wb_adr_i == OFS_ARB_ID) begin
            nxt_dat = {21'h00_0000, idma_id_ff, 1'b0, serial_dma_channel_id_ff, 1'b0, bclr_id_ff};
        end else if (is_bank(wb_adr_i, 1'b0)) begin
            nxt_dat = bank_base_cfg_ff[wb_adr_i[5:3]];
        end else if (is_bank(wb_adr_i, 1'b1)) begin
            nxt_dat = bank_size_timing_cfg_ff[wb_adr_i[5:3]];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req && !wb_we_i) begin
            wb_dat_o <= nxt_dat;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            global_mem_cfg_ff <= GLOBAL_RESET;
            bclr_id_ff        <= BCLR_ID_RESET;
            serial_dma_channel_id_ff        <= SERIAL_DMA_CHANNEL_ID_RESET;
            idma_id_ff        <= IDMA_ID_RESET;
        end else if (wb_wr && wb_adr_i == OFS_GLOBAL) begin
            global_mem_cfg_ff <= merge(global_mem_cfg_ff, wb_dat_i, wb_sel_i);
        end else if (wb_wr && wb_adr_i == OFS_ARB_ID) begin
            if (wb_sel_i[0]) begin
                bclr_id_ff <= wb_dat_i[ARB_BCLR_LSB +: 3];
                serial_dma_channel_id_ff <= wb_dat_i[ARB_SERIAL_DMA_CHANNEL_LSB +: 3];
            end
            if (wb_sel_i[1]) begin
                idma_id_ff <= wb_dat_i[ARB_IDMA_LSB +: 3];
            end
        end
    end

    // Per-bank configuration, banks reset unused
    always_ff @(posedge clk) begin
        if (rst) begin
            bank_base_cfg_ff        <= '0;
            bank_size_timing_cfg_ff <= '0;
        end else if (wb_wr && is_bank(wb_adr_i, 1'b0)) begin
            bank_base_cfg_ff[wb_adr_i[5:3]] <= merge(bank_base_cfg_ff[wb_adr_i[5:3]], wb_dat_i,
                                                     wb_sel_i); // R2
        end else if (wb_wr && is_bank(wb_adr_i, 1'b1)) begin
            bank_size_timing_cfg_ff[wb_adr_i[5:3]] <=
                merge(bank_size_timing_cfg_ff[wb_adr_i[5:3]], wb_dat_i, wb_sel_i); // R2
        end
    end

    // Fault flags, write one to clear, a new fault wins over the clear
    always_comb begin
        fault_set = '0;
        fault_set[FLT_WP_BIT]  = wp_fault; // R8
        fault_set[FLT_PAR_BIT] = par_fault; // R8
        fault_clr = (wb_wr && wb_adr_i == OFS_FAULT && wb_sel_i[0]) ? wb_dat_i[1:0] : 2'b00;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mem_fault_flags_ff <= 2'b00;
        end else begin
            mem_fault_flags_ff <= (mem_fault_flags_ff & ~fault_clr) | fault_set;
        end
    end

    // Refresh timer: one tick every (count + 2) prescaler periods
    assign refresh_tick = (prescale_ff == 8'(PRESCALE_CYCLES - 1)) && (interval_ff == 8'h00);

    always_ff @(posedge clk) begin
        if (rst || !global_mem_cfg_ff[GL_REFRESH_ON_BIT_BIT]) begin
            prescale_ff <= 8'h00;
            interval_ff <= 8'h00;
        end else if (prescale_ff == 8'(PRESCALE_CYCLES - 1)) begin
            prescale_ff <= 8'h00;
            interval_ff <= (interval_ff == 8'h00) ?
                           global_mem_cfg_ff[GL_REFRESH_INTERVAL_COUNT_LSB +: GL_REFRESH_INTERVAL_COUNT_W] + 8'h01 :
                           interval_ff - 8'h01; // R1
        end else begin
            prescale_ff <= prescale_ff + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            refresh_pend_ff <= 1'b0;
        end else if (refresh_tick && global_mem_cfg_ff[GL_REFRESH_ON_BIT_BIT] && |dram_valid) begin
            refresh_pend_ff <= 1'b1; // R18
        end else if (state_ff == S_REFRESH) begin
            refresh_pend_ff <= 1'b0;
        end
    end

    // Bus clear toward independent DMA
    always_ff @(posedge clk) begin
        if (rst) begin
            idma_clear <= 1'b0;
        end else begin
            idma_clear <= idma_busy && ((serial_dma_channel_req && serial_dma_channel_id_ff > bclr_id_ff
                                         && serial_dma_channel_id_ff > idma_id_ff) || refresh_pend_ff); // R16
        end
    end

    // Access sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff    <= S_IDLE;
            bank_idx_ff <= 3'h0;
            wait_cnt_ff <= 5'h00;
            beat_cnt_ff <= 2'h0;
        end else begin
            unique case (state_ff)
                S_IDLE: begin
                    if (refresh_pend_ff) begin
                        state_ff <= S_REFRESH;
                    end else if (acc_req && hit && !wp_fault) begin
                        state_ff    <= S_WAIT;
                        bank_idx_ff <= hit_idx;
                        beat_cnt_ff <= 2'(BURST_BEATS - 1);
                        wait_cnt_ff <= {1'b0, bank_size_timing_cfg_ff[hit_idx].access_wait_count}
                                       + 5'((pg_wait && bank_size_timing_cfg_ff[hit_idx]
                                             .dram_bank_select) ? 1 : 0); // R4
                    end else if (acc_req) begin
                        state_ff <= S_END;
                    end
                end
                S_WAIT, S_BEAT: begin
                    if (!beat_done) begin
                        wait_cnt_ff <= wait_cnt_ff - 5'h01;
                    end else if (acc.burst && bank_base_cfg_ff[bank_idx_ff].host_burst_ack_on
                                 && beat_cnt_ff != 2'h0 && !(par_fault && pbf_on)) begin
                        state_ff    <= S_BEAT; // R7
                        beat_cnt_ff <= beat_cnt_ff - 2'h1;
                        wait_cnt_ff <= {3'h0, bank_size_timing_cfg_ff[bank_idx_ff]
                                        .burst_beat_wait}; // R6
                    end else begin
                        state_ff <= S_END;
                    end
                end
                S_END: begin
                    if (!acc_req) begin
                        state_ff <= S_IDLE;
                    end
                end
                S_REFRESH: begin
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end

    // Registered outputs toward memory and requester
    always_ff @(posedge clk) begin
        if (rst) begin
            bank_sel_n   <= 8'hFF;
            acc_ack      <= 1'b0;
            acc_berr     <= 1'b0;
            acc_miss     <= 1'b0;
            refresh_busy <= 1'b0;
        end else begin
            bank_sel_n   <= 8'hFF;
            acc_ack      <= 1'b0;
            acc_berr     <= wp_fault || (par_fault && pbf_on); // R11
            acc_miss     <= start && !hit;
            refresh_busy <= (state_ff == S_IDLE) && refresh_pend_ff;
            if (state_ff == S_IDLE && refresh_pend_ff) begin
                bank_sel_n <= ~dram_valid; // R13
            end else if (start && hit && !wp_fault) begin
                bank_sel_n <= ~(8'h01 << hit_idx); // R20
            end else if ((state_ff == S_WAIT || state_ff == S_BEAT) && !(beat_done &&
                         (state_ff_next_end(beat_cnt_ff)))) begin
                bank_sel_n <= ~(8'h01 << bank_idx_ff);
            end
            if ((state_ff == S_WAIT || state_ff == S_BEAT) && beat_done) begin
                acc_ack <= !(par_fault && pbf_on);
            end
        end
    end

    function automatic logic state_ff_next_end(input logic [1:0] beats);
        state_ff_next_end = !(acc.burst && bank_base_cfg_ff[bank_idx_ff].host_burst_ack_on
                              && beats != 2'h0 && !(par_fault && pbf_on));
    endfunction : state_ff_next_end

    // Assertion helpers
    logic [11:0] tick_gap_ff;
    logic        tick_seen_ff;
    always_ff @(posedge clk) begin
        if (rst || !global_mem_cfg_ff[GL_REFRESH_ON_BIT_BIT] || (wb_wr && wb_adr_i == OFS_GLOBAL)) begin
            tick_gap_ff  <= 12'h000;
            tick_seen_ff <= 1'b0;
        end else if (refresh_tick) begin
            tick_gap_ff  <= 12'h001;
            tick_seen_ff <= 1'b1;
        end else begin
            tick_gap_ff  <= tick_gap_ff + 12'h001;
        end
    end

    property p_refresh_period;
        @(posedge clk) disable iff (rst)
        refresh_tick && tick_seen_ff |-> tick_gap_ff ==
            12'(PRESCALE_CYCLES * (global_mem_cfg_ff[GL_REFRESH_INTERVAL_COUNT_LSB +: GL_REFRESH_INTERVAL_COUNT_W] + 2));
    endproperty
    a_refresh_period: assert property (p_refresh_period) // R1
        else $error("refresh spacing wrong");

    property p_refresh_needs_enable;
        @(posedge clk) disable iff (rst)
        !global_mem_cfg_ff[GL_REFRESH_ON_BIT_BIT] && !refresh_pend_ff |=> !refresh_busy;
    endproperty
    a_refresh_needs_enable: assert property (p_refresh_needs_enable) // R18
        else $error("refresh while off");

    property p_one_select;
        @(posedge clk) disable iff (rst)
        !refresh_busy |-> $onehot0(~bank_sel_n);
    endproperty
    a_one_select: assert property (p_one_select) else $error("more than one bank selected"); // R20

    property p_select_valid;
        @(posedge clk) disable iff (rst)
        ((~bank_sel_n) & ~$past(bank_valid)) == 8'h00;
    endproperty
    a_select_valid: assert property (p_select_valid) else $error("invalid bank selected"); // R12

    property p_write_guard;
        @(posedge clk) disable iff (rst)
        wp_fault |=> acc_berr && bank_sel_n == 8'hFF && mem_fault_flags_ff[FLT_WP_BIT];
    endproperty
    a_write_guard: assert property (p_write_guard) else $error("guarded write not refused"); // R9

    property p_zero_wait;
        @(posedge clk) disable iff (rst)
        start && hit && !wp_fault && bank_size_timing_cfg_ff[hit_idx].access_wait_count == 4'h0
        && !pg_wait |=> ##1 (acc_ack || acc_berr);
    endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("wait count not honoured"); // R4

    property p_two_clock_beat;
        @(posedge clk) disable iff (rst)
        state_ff == S_BEAT && beat_done && bank_size_timing_cfg_ff[bank_idx_ff].burst_beat_wait
        == 2'b01 |=> ##1 !acc_ack;
    endproperty
    a_two_clock_beat: assert property (p_two_clock_beat) else $error("beat too short"); // R6

    property p_parity_fault;
        @(posedge clk) disable iff (rst)
        acc_berr && !$past(wp_fault) |-> $past(pbf_on) && !$past(companion_mode);
    endproperty
    a_parity_fault: assert property (p_parity_fault) // R11
        else $error("parity bus error not enabled");

    property p_preempt;
        @(posedge clk) disable iff (rst)
        idma_busy && refresh_pend_ff |=> idma_clear;
    endproperty
    a_preempt: assert property (p_preempt) else $error("refresh did not clear dma"); // R16

    c_burst:   cover property (@(posedge clk) disable iff (rst) state_ff == S_BEAT ##1 acc_ack);
    c_refresh: cover property (@(posedge clk) disable iff (rst) refresh_busy);
    c_parity:  cover property (@(posedge clk) disable iff (rst) par_fault);
endmodule : bank_select_refresh_ctrl
`default_nettype wire

// ### testbench/mem_bank_model.sv
// Memory bank model that reports parity faults on selected beats
`timescale 1ns/10ps
`default_nettype none
module mem_bank_model (
    input  wire logic       bad_parity,
    input  wire logic [7:0] bank_sel_n,
    output logic            parity_err_in
);
    assign parity_err_in = bad_parity && (bank_sel_n != 8'hFF);
endmodule : mem_bank_model
`default_nettype wire

// ### testbench/bank_select_refresh_ctrl_test.sv
// Testbench of the bank select and refresh controller
`timescale 1ns/10ps
`default_nettype none
module bank_select_refresh_ctrl_test;
    import mem_ctrl_pkg::*;
    logic           clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, acc_req = 0, bad = 0;
    logic [7:0]     adr = 0, bank_sel_n;
    logic [3:0]     sel = 0;
    logic [31:0]    dat = 0, wb_dat_o, q[$];
    access_req_type acc = '0;
    logic           wb_ack_o, acc_ack, acc_berr, acc_miss, refresh_busy, perr;
    logic           comp = 0, wl = 0, sd = 0, ib = 0, iclr;
    int             error_cnt = 0, num_checks = 0, resp, lat = 0, rc = 0, rf_n = 0, w, i, b, k;
    initial forever #20 clk = ~clk;
    bank_select_refresh_ctrl u_bank_select_refresh_ctrl (.clk(clk), .rst(rst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .acc_req(acc_req),
        .acc(acc), .parity_err_in(perr), .companion_mode(comp), .we_lines_mode(wl),
        .serial_dma_channel_req(sd), .idma_busy(ib), .bank_sel_n(bank_sel_n), .acc_ack(acc_ack),
        .acc_berr(acc_berr), .acc_miss(acc_miss), .refresh_busy(refresh_busy),
        .idma_clear(iclr));
    mem_bank_model u_mem_bank_model (.bad_parity(bad), .bank_sel_n(bank_sel_n),
        .parity_err_in(perr));
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim
    task hang(input string n);
        chk(n, 1, 0);
        end_sim();
    endtask : hang
    task wb(input logic w_e, input logic [7:0] a, input logic [31:0] d);
        int t;
        {cyc, stb, we, adr, sel, dat} <= {2'b11, w_e, a, 4'hF, d};
        if (!w_e) q.push_back(d);
        for (t = 0; t < 9 && wb_ack_o !== 1'b1; t++) @(negedge clk);
        if (t == 9) hang("wb timeout");
        @(posedge clk);
        {cyc, stb} <= 2'b00;
        @(posedge clk);
    endtask : wb
    task ex(input int l, input logic [2:0] f);
        q.push_back({l[28:0], f});
    endtask : ex
    task ar(input logic [31:0] a, input logic [3:0] fc, input logic wr, bu, input int n);
        int t;
        resp = 0;
        acc_req <= 1;
        acc <= '{a, fc, wr, bu};
        for (t = 0; t < 200 && resp < n; t++) @(negedge clk);
        if (t == 200) hang("acc timeout");
        @(posedge clk);
        acc_req <= 0;
        @(posedge clk);
    endtask : ar
    always @(posedge clk) begin
        if (wb_ack_o && !we) chk("wb_dat_o", q.pop_front(), wb_dat_o);
        if (acc_ack || acc_berr || acc_miss) begin
            chk("acc", q.pop_front(), {lat[28:0], acc_ack, acc_berr, acc_miss});
            resp++;
        end
        if (refresh_busy) begin
            if (rf_n > 0) chk("refresh gap", 15 * 26, rc + 1);
            chk("refresh sel", 8'hFB, bank_sel_n);
            chk("idma clear", 1, iclr);
            rf_n++;
        end
        rc = refresh_busy ? 0 : rc + 1;
        lat = acc_req ? lat + 1 : 0;
    end
    initial begin
        void'($urandom(32'hc2629919));
        repeat (2) @(posedge clk);
        rst <= 0;
        wb(0, OFS_GLOBAL, 32'h0);
        wb(0, OFS_ARB_ID, 32'h0000_0243);
        wb(0, 8'hFC, 32'h0);
        $display("register test done");
        w = $urandom_range(3);
        wb(1, 8'h50, 32'h0010_0001);
        wb(1, 8'h54, {w[3:0], 28'hFFF_F800});
        for (i = 0; i < 8; i++) begin
            ex(i == 7 ? 1 : 2 + w, i == 7 ? 1 : 4);
            ar(32'h0010_0004, i[3:0], 0, 0, 1);
        end
        ex(1, 1);
        ar(32'h0010_0804, 1, 0, 0, 1);
        $display("decode test done");
        wb(1, 8'h50, 32'h0010_0009);
        for (b = 0; b < 2; b++) begin
            wb(1, 8'h54, {w[3:0], 28'hFFF_F800} + (b << 1));
            for (k = 0; k < 4; k++) ex(2 + w + k * (b + 1), 4);
            ar(32'h0010_0004, 1, 0, 1, 4);
        end
        $display("burst test done");
        wb(1, 8'h50, 32'h0010_0003);
        ex(1, 2);
        ar(32'h0010_0004, 1, 1, 0, 1);
        wb(0, OFS_FAULT, 32'h1);
        wb(1, OFS_FAULT, 32'h3);
        wb(1, OFS_GLOBAL, 32'h200);
        wb(1, 8'h50, 32'h0010_0005);
        wb(1, 8'h54, 32'h0FFF_F800);
        bad <= 1;
        ex(2, 2);
        ar(32'h0010_0004, 1, 0, 0, 1);
        comp <= 1;
        ex(2, 4);
        ar(32'h0010_0004, 1, 0, 0, 1);
        {comp, bad, wl} <= 3'b001;
        ex(2, 4);
        ar(32'hF010_0004, 1, 0, 0, 1);
        wl <= 0;
        wb(0, OFS_FAULT, 32'h2);
        wb(1, 8'h50, 32'h0010_0000);
        ex(1, 1);
        ar(32'h0010_0004, 1, 0, 0, 1);
        $display("fault test done");
        wb(1, 8'h50, 32'h0010_0001);
        wb(1, 8'h54, {w[3:0], 28'hFFF_F801});
        ib <= 1;
        wb(1, OFS_GLOBAL, 32'h118);
        repeat (900) @(posedge clk);
        chk("refresh count", 1, rf_n >= 2);
        sd <= 1;
        repeat (3) @(posedge clk);
        chk("serial_dma_channel clear", 1, iclr);
        $display("refresh test done");
        end_sim();
    end
endmodule : bank_select_refresh_ctrl_test
`default_nettype wire
